// ==== logic/timer8_pkg.sv ====
// Purpose: Shared constants for the eight-bit timer/event counter.
// Assumes: One system clock; register index space of four byte registers.
// Notes:   Offsets, field positions, reset values and divider tables live here.
package timer8_pkg;

  // ----------------------------------------------------------------
  // Register indices on the CPU register port
  // ----------------------------------------------------------------
  localparam logic [1:0] COUNT_IDX = 2'h0;   // Count register, read-only
  localparam logic [1:0] MATCH_IDX = 2'h1;   // Match register
  localparam logic [1:0] CLKSEL_IDX = 2'h2;  // Clock select register
  localparam logic [1:0] MODE_IDX = 2'h3;    // Mode control register

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Mode control register field positions
  // ----------------------------------------------------------------
  localparam int MODE_ENABLE_POS = 7;  // Count enable bit
  localparam int MODE_PWM_POS = 6;     // PWM mode select bit
  localparam int MODE_SET_POS = 3;     // Output flop set, write-only
  localparam int MODE_CLR_POS = 2;     // Output flop reset, write-only
  localparam int MODE_INV_POS = 1;     // Invert enable / active-low select
  localparam int MODE_OE_POS = 0;      // Timer output enable

  // ----------------------------------------------------------------
  // Clock select codes and prescaler
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_EXT_FALL = 3'h0;  // External input falling edge
  localparam logic [2:0] SEL_EXT_RISE = 3'h1;  // External input rising edge
  localparam logic [2:0] SEL_SYS = 3'h2;       // Undivided system clock
  localparam int PRESCALE_W = 13;              // Enough for divide by 8192
  localparam logic [7:0] COUNT_MAX = 8'hFF;    // Overflow point

  // Divider exponent for codes 3..7, per instance
  localparam logic [3:0] INST0_SHIFT [3:7] = '{4'h1, 4'h2, 4'h6, 4'h8, 4'hD};
  localparam logic [3:0] INST1_SHIFT [3:7] = '{4'h1, 4'h4, 4'h6, 4'h8, 4'hC};

endpackage

// ==== logic/timer8.sv ====
// Behaviour
// RULE1: Counter increments once per selected count tick
// RULE2: Clear on reset, disable, or match
// RULE3: Counter is read-only; writes ignored
// RULE4: Non-PWM equality raises match interrupt request
// RULE5: PWM output active at overflow, inactive on match
// RULE6: Full-range read/write match register, resets zero
// RULE7: Software keeps match register fixed while matching
// RULE8: PWM match rewrites three count ticks apart
// RULE9: Instance 0 clock-select decode table
// RULE10: Instance 1 clock-select decode table
// RULE11: Software stops timer before clock-select writes
// RULE12: Software writes zeros to upper select bits
// RULE13: Clock select resets to external falling edge
// RULE14: Disable holds counter cleared; enable starts it
// RULE15: Mode bit picks clear-on-match or PWM
// RULE16: External input synchronised, edge becomes tick
//
// Purpose: Eight-bit timer/event counter with match interrupt and PWM output.
// Assumes: mclk is the system oscillator clock; CPU port is synchronous.
// Notes:   INSTANCE picks the divider table; read data is one cycle late.
`timescale 1ns/10ps
module timer8
  import timer8_pkg::*;
#(
  parameter int INSTANCE = 0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // CPU register port
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Pins and events
  input wire logic external_count_input,
  output logic timer_output_pin,
  output logic match_interrupt_request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] count_register;           // Running count
  logic [7:0] match_register;           // Compare value
  logic [2:0] clock_select_register;    // Count source code
  logic count_enable_bit;               // Run / stop
  logic pwm_mode_select_bit;            // 0 clear-on-match, 1 PWM
  logic invert_bit;                     // Toggle enable or active-low
  logic out_enable;                     // Output pin enable
  logic out_flop;                       // Timer output flop, non-PWM
  logic pwm_active;                     // PWM phase: active after overflow
  logic match_prev;                     // Last cycle's match level
  logic [PRESCALE_W-1:0] prescale;      // Free divider chain
  logic ext_s1, ext_s2, ext_s3;         // Input synchroniser and edge tap

  logic [7:0] next_count, next_match, next_rdata;
  logic [2:0] next_clksel;
  logic next_en, next_pwm, next_inv, next_oe, next_flop, next_active;
  logic next_irq, next_pin, next_match_prev;
  logic [PRESCALE_W-1:0] next_prescale;

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  logic count_tick;   // One-cycle count pulse
  logic match_now;    // Counter equals match register
  logic match_edge;   // First cycle of equality
  logic [3:0] shift;
  logic [PRESCALE_W-1:0] mask;
  logic wr_mode;

  // Divider exponent lookup and tick selection
  always_comb begin
    shift = 4'h0;
    mask = '0;
    count_tick = 1'b0;
    if (clock_select_register >= 3'h3) begin
      // RULE10: instance 1 divider table
      if (INSTANCE == 1) begin
        shift = INST1_SHIFT[clock_select_register];
      end else begin
        // RULE9: instance 0 divider table
        shift = INST0_SHIFT[clock_select_register];
      end
    end
    mask = PRESCALE_W'((14'h0001 << shift) - 14'h0001);
    // RULE9: source decode per code
    unique case (clock_select_register)
      // RULE16: synchronised falling edge
      SEL_EXT_FALL: count_tick = ext_s3 & ~ext_s2;
      // RULE16: synchronised rising edge
      SEL_EXT_RISE: count_tick = ext_s2 & ~ext_s3;
      SEL_SYS: count_tick = 1'b1;
      3'h3, 3'h4, 3'h5, 3'h6, 3'h7: count_tick = (prescale & mask) == mask;
    endcase
  end

  assign match_now = (count_register == match_register);
  assign match_edge = match_now & ~match_prev;
  assign wr_mode = reg_wr && reg_addr == MODE_IDX;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Counter, registers, output flops and read data
  always_comb begin
    next_count = count_register;
    next_match = match_register;
    next_clksel = clock_select_register;
    next_en = count_enable_bit;
    next_pwm = pwm_mode_select_bit;
    next_inv = invert_bit;
    next_oe = out_enable;
    next_flop = out_flop;
    next_active = pwm_active;
    next_irq = 1'b0;
    next_prescale = prescale + PRESCALE_W'(1);
    next_rdata = reg_rdata;
    // Level is kept only while running or in PWM mode, so a clear-mode restart re-arms it
    next_match_prev = match_now & (count_enable_bit | pwm_mode_select_bit);

    // Counter behaviour
    if (!count_enable_bit) begin
      // RULE14: stopped counter held at zero
      next_count = COUNT_RESET;
      next_active = 1'b0;
      // Prescaler restarts so the first divided tick has a fixed delay
      next_prescale = '0;
    end else if (!pwm_mode_select_bit) begin
      // RULE15: clear-and-start mode
      if (match_edge) begin
        // RULE4: match raises the request
        next_irq = 1'b1;
        if (invert_bit) begin
          next_flop = ~out_flop;
        end
      end
      if (count_tick) begin
        // RULE2: match clears at the next tick
        if (match_now) begin
          next_count = COUNT_RESET;
        end else begin
          // RULE1: advance by one
          next_count = count_register + 8'h01;
        end
      end
    end else begin
      // RULE15: free-running PWM mode
      if (count_tick) begin
        next_count = count_register + 8'h01;
      end
      // RULE5: overflow activates, later match deactivates
      if (count_tick && count_register == COUNT_MAX) begin
        next_active = 1'b1;
      end else if (match_edge) begin
        next_active = 1'b0;
      end
    end

    // Register writes; a counter write has no effect
    // RULE3: no write path to the counter
    if (reg_wr) begin
      unique case (reg_addr)
        COUNT_IDX: next_count = next_count;
        // RULE6: any byte value accepted
        MATCH_IDX: next_match = reg_wdata;
        CLKSEL_IDX: next_clksel = reg_wdata[2:0];
        MODE_IDX: begin
          next_en = reg_wdata[MODE_ENABLE_POS];
          next_pwm = reg_wdata[MODE_PWM_POS];
          next_inv = reg_wdata[MODE_INV_POS];
          next_oe = reg_wdata[MODE_OE_POS];
          // Set/reset act outside PWM only; both at once is ignored
          if (!reg_wdata[MODE_PWM_POS]) begin
            if (reg_wdata[MODE_SET_POS] && !reg_wdata[MODE_CLR_POS]) begin
              next_flop = 1'b1;
            end else if (!reg_wdata[MODE_SET_POS] && reg_wdata[MODE_CLR_POS]) begin
              next_flop = 1'b0;
            end
          end
        end
      endcase
    end

    // Pin level: gated by enable, inverted for active-low PWM
    if (!out_enable) begin
      next_pin = 1'b0;
    end else if (pwm_mode_select_bit) begin
      next_pin = pwm_active ^ invert_bit;
    end else begin
      next_pin = out_flop;
    end

    // Read data; write-only and unused bits read zero
    if (reg_rd) begin
      unique case (reg_addr)
        COUNT_IDX: next_rdata = count_register;
        MATCH_IDX: next_rdata = match_register;
        CLKSEL_IDX: next_rdata = {5'h00, clock_select_register};
        MODE_IDX: next_rdata = {count_enable_bit, pwm_mode_select_bit, 4'h0, invert_bit, out_enable};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Constants only under reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      // RULE2: reset clears the counter
      count_register <= COUNT_RESET;
      // RULE6: match register resets to zero
      match_register <= MATCH_RESET;
      // RULE13: default source is external falling edge
      clock_select_register <= CLKSEL_RESET;
      count_enable_bit <= MODE_RESET[MODE_ENABLE_POS];
      pwm_mode_select_bit <= MODE_RESET[MODE_PWM_POS];
      invert_bit <= MODE_RESET[MODE_INV_POS];
      out_enable <= MODE_RESET[MODE_OE_POS];
      out_flop <= 1'b0;
      pwm_active <= 1'b0;
      match_prev <= 1'b0;
      prescale <= '0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      reg_rdata <= 8'h00;
      timer_output_pin <= 1'b0;
      match_interrupt_request <= 1'b0;
    end else begin
      count_register <= next_count;
      match_register <= next_match;
      clock_select_register <= next_clksel;
      count_enable_bit <= next_en;
      pwm_mode_select_bit <= next_pwm;
      invert_bit <= next_inv;
      out_enable <= next_oe;
      out_flop <= next_flop;
      pwm_active <= next_active;
      match_prev <= next_match_prev;
      prescale <= next_prescale;
      // RULE16: two-flop synchroniser plus edge tap
      ext_s1 <= external_count_input;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      reg_rdata <= next_rdata;
      timer_output_pin <= next_pin;
      match_interrupt_request <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_count_step_one: assert property (count_enable_bit && count_tick && !match_now && !wr_mode // RULE1
    |=> count_register == $past(count_register) + 8'h01) else $error("count did not step by one");
  a_match_clears_count: assert property (count_enable_bit && !pwm_mode_select_bit && count_tick && match_now // RULE2
    && !wr_mode |=> count_register == 8'h00) else $error("match did not clear count");
  a_count_write_ignored: assert property (count_enable_bit && !count_tick && !wr_mode // RULE3
    |=> count_register == $past(count_register)) else $error("count changed without tick");
  a_match_raises_irq: assert property (count_enable_bit && !pwm_mode_select_bit && match_edge // RULE4
    |=> match_interrupt_request ##1 !match_interrupt_request) else $error("match request not one pulse");
  a_pwm_overflow_active: assert property (count_enable_bit && pwm_mode_select_bit && count_tick // RULE5
    && count_register == COUNT_MAX && !wr_mode |=> pwm_active ##1 (timer_output_pin == (out_enable & ~invert_bit)))
    else $error("overflow did not activate output");
  a_match_write_stored: assert property (reg_wr && reg_addr == MATCH_IDX // RULE6
    |=> match_register == $past(reg_wdata)) else $error("match write lost");
  a_sys_clock_ticks: assert property (clock_select_register == SEL_SYS |-> count_tick) // RULE9
    else $error("system clock code not ticking");
  a_stop_holds_zero: assert property ((!count_enable_bit && !wr_mode) [*2] |-> count_register == 8'h00) // RULE14
    else $error("stopped counter not zero");
  a_ext_rise_ticks: assert property (clock_select_register == SEL_EXT_RISE && $rose(ext_s2) // RULE16
    |-> count_tick) else $error("rising edge not counted");

  c_match_irq: cover property (match_interrupt_request);
  c_pwm_cycle: cover property (pwm_active ##[1:600] !pwm_active);
  c_ext_fall_tick: cover property (clock_select_register == SEL_EXT_FALL && count_tick);

endmodule

// ==== verif/ext_pin_model.sv ====
// Purpose: Far-side model of the external count pin.
// Assumes: The pin is always driven, so it never floats between bursts.
// Notes:   Four cycles high and four low clears the three-flop synchroniser.
`timescale 1ns/10ps
module ext_pin_model (
  // Clock
  input wire logic mclk,
  // Burst request
  input wire logic go,
  input wire logic [7:0] n_pulses,
  // Pin and status
  output logic pin,
  output logic busy
);
  // Idle low, so a falling-edge select sees nothing until a burst starts
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end

  // Whole pulses only; each one gives exactly one rise and one fall
  always begin
    @(posedge mclk);
    if (go === 1'b1) begin
      busy = 1'b1;
      repeat (n_pulses) begin
        #1 pin = 1'b1;
        repeat (4) @(posedge mclk);
        #1 pin = 1'b0;
        repeat (4) @(posedge mclk);
      end
      busy = 1'b0;
    end
  end
endmodule

// ==== verif/test_timer8.sv ====
// Purpose: Self-checking bench for the timer, both divider tables at once.
// Assumes: Read data lands one cycle after the strobe; the match request is a pulse.
// Notes:   Both instances share the register port, so every write lands in both.
`timescale 1ns/10ps
module test_timer8
  import timer8_pkg::*;
();
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  wire logic [7:0] rdata [2];
  wire logic [1:0] pin;
  wire logic [1:0] irq;
  logic ext_in;
  logic go = 1'b0;
  logic [7:0] n_pulses = 8'h00;
  logic busy;
  logic [15:0] p;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  int hi;
  int nirq;
  // Divider exponents for codes 3..7, written out here on their own
  logic [3:0] shift [2][8] = '{'{4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h6, 4'h8, 4'hD},
                               '{4'h0, 4'h0, 4'h0, 4'h1, 4'h4, 4'h6, 4'h8, 4'hC}};

  // 200 MHz system clock
  always #2.5 mclk = ~mclk;

  // One instance per divider table
  for (genvar g = 0; g < 2; g++) begin : g_inst
    timer8 #(.INSTANCE(g)) DUT (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata[g]), .external_count_input(ext_in),
      .timer_output_pin(pin[g]), .match_interrupt_request(irq[g]));
  end
  ext_pin_model far_pin (.mclk(mclk), .go(go), .n_pulses(n_pulses), .pin(ext_in), .busy(busy));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One cycle of a bounded wait; running out counts as a mismatch
  task automatic step(inout int k);
    k++;
    if (k > 40000) begin
      n_mismatch++;
      summarize();
    end
    @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
  endtask

  // Both instances must return the same byte
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    check({rdata[1], rdata[0]}, {exp, exp});
  endtask

  // Cycles between two consecutive match requests of one instance
  task automatic period(input int g, output logic [15:0] q);
    int k;
    k = 0;
    while (irq[g] !== 1'b1) step(k);
    k = 0;
    step(k);
    while (irq[g] !== 1'b1) step(k);
    q = 16'(k);
  endtask

  task automatic pulse(input logic [7:0] cnt);
    int k;
    @(posedge mclk);
    #1;
    n_pulses = cnt;
    go = 1'b1;
    @(posedge mclk);
    #1;
    go = 1'b0;
    k = 0;
    while (busy === 1'b1) step(k);
    repeat (6) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    #1 rstn = 1'b1;
    rd_chk(COUNT_IDX, 8'h00);
    rd_chk(MATCH_IDX, 8'h00);
    rd_chk(CLKSEL_IDX, 8'h00);
    wr(MATCH_IDX, 8'hFF);
    rd_chk(MATCH_IDX, 8'hFF);
    wr(COUNT_IDX, 8'h5A);
    rd_chk(COUNT_IDX, 8'h00);
    // Undivided clock, match 2: request every third cycle
    // stopped, upper bits zero
    wr(CLKSEL_IDX, 8'(SEL_SYS));
    wr(MATCH_IDX, 8'h02);
    wr(MODE_IDX, 8'h80);
    period(0, p);
    check(p, 16'h0003);
    // Every divided code, stopped before each select change
    for (int c = 3; c < 8; c++) begin
      wr(MODE_IDX, 8'h00);
      wr(MATCH_IDX, 8'h01);
      wr(CLKSEL_IDX, 8'(c));
      wr(MODE_IDX, 8'h80);
      for (int g = 0; g < 2; g++) begin
        period(g, p);
        check(p, 16'h0002 << shift[g][c]);
      end
    end
    // Both external edges; a top match keeps the count from clearing
    for (int c = 0; c < 2; c++) begin
      wr(MODE_IDX, 8'h00);
      wr(MATCH_IDX, 8'hFF);
      wr(CLKSEL_IDX, 8'(c));
      wr(MODE_IDX, 8'h80);
      pulse(8'h05);
      rd_chk(COUNT_IDX, 8'h05);
      // A running, idle counter must ignore a write
      wr(COUNT_IDX, 8'h5A);
      rd_chk(COUNT_IDX, 8'h05);
    end
    // Disabled: cleared and deaf to the pin
    wr(MODE_IDX, 8'h00);
    pulse(8'h03);
    rd_chk(COUNT_IDX, 8'h00);
    // PWM, match 0x40: active for 0x41 cycles of each 256, no request
    // stopped, upper bits zero
    wr(CLKSEL_IDX, 8'(SEL_SYS));
    wr(MATCH_IDX, 8'h40);
    wr(MODE_IDX, 8'h41);
    wr(MODE_IDX, 8'hC1);
    n = 0;
    while (pin[0] !== 1'b1) step(n);
    hi = 0;
    nirq = 0;
    repeat (256) begin
      hi += (pin === 2'b11);
      nirq += (irq !== 2'b00);
      @(posedge mclk);
      #1;
    end
    check(16'(hi), 16'h0041);
    check(16'(nirq), 16'h0000);
    // Window ends as the next active phase starts; stopping must drop the pin
    wr(MODE_IDX, 8'h41);
    rd_chk(MODE_IDX, 8'h41);
    check(16'(pin), 16'h0000);
    summarize();
  end
endmodule
